// *** core/rs_oneway_pkg.sv ***
// Constants and types shared by the one-way fault-aware transmit reconciliation logic
package rs_oneway_pkg;

  // ------------------------------------------------------------
  // Column geometry
  // ------------------------------------------------------------
  localparam int LANES      = 4;
  localparam int DATA_W     = 32;

  // ------------------------------------------------------------
  // Control characters and ordered sets, lane 0 in the low byte
  // ------------------------------------------------------------
  localparam logic [3:0]  IDLE_C    = 4'hF;
  localparam logic [31:0] IDLE_D    = 32'h07070707;
  localparam logic [3:0]  RFAULT_C  = 4'h1;
  localparam logic [31:0] RFAULT_D  = 32'h0200009C;
  localparam logic [3:0]  ERROR_C   = 4'hF;
  localparam logic [31:0] ERROR_D   = 32'hFEFEFEFE;

  // ------------------------------------------------------------
  // Buffer geometry
  // ------------------------------------------------------------
  localparam int BUF_DEPTH  = 2;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    FAULT_OK     = 2'h0,
    FAULT_LOCAL  = 2'h1,
    FAULT_REMOTE = 2'h2
  } fault_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_FRAME = 2'h1,
    ST_GAP   = 2'h3,
    ST_DROP  = 2'h2
  } txstate_t;

endpackage : rs_oneway_pkg

// *** core/rs_oneway_tx.sv ***
// Transmit reconciliation with link fault signalling and one-way transmit mode
//
// Behaviour
// - A one-way permit input selects normal fault handling or one-way transmit.
// - Output is a 4-bit control lane set plus a 32-bit data lane set.
// - No fault: forward MAC frames, send Idle columns when nothing is pending.
// - Local Fault, no permit: cut MAC data at once, send Remote Fault continuously.
// - Local Fault with permit: keep forwarding frames, gaps carry Remote Fault.
// - Local Fault with permit: one full Idle column after every frame end.
// - Local Fault with permit and no frame pending: send Remote Fault sets.
// - Remote Fault, no permit: stop MAC data, send Idle columns continuously.
// - Remote Fault with permit: forward frames, Idle columns when nothing pending.
// - Fault gone: return to normal forwarding with Idle fill.
`timescale 1ns/100ps
`default_nettype none
module rs_oneway_tx
  import rs_oneway_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [31:0] macData,
  input  wire logic [3:0]  macCtrl,
  input  wire logic        macLast,
  input  wire logic        macValid,
  output logic             macReady,
  input  wire logic [1:0]  linkFault,
  input  wire logic        mgmtOnewayTxPermit,
  output logic [31:0]      txd,
  output logic [3:0]       txc
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int W  = DATA_W + LANES + 1;

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic [1:0] rstSync;
  logic       rstn;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstn = rstSync[1];

  // ------------------------------------------------------------
  // Two-entry column buffer
  // ------------------------------------------------------------
  // Absorbs a stall while a gap column is inserted without losing a word.
  function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1)) begin
      return '0;
    end
    return p + AW'(1);
  endfunction : nextPtr

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0]   count;
  logic          bufValid;
  logic          bufPop;
  logic          push;
  logic          pop;
  logic [31:0]   bufData;
  logic [3:0]    bufCtrl;
  logic          bufLast;

  assign macReady = (count != (AW+1)'(DEPTH));
  assign bufValid = (count != '0);
  assign push     = macValid && macReady;
  assign pop      = bufValid && bufPop;
  assign {bufLast, bufCtrl, bufData} = mem[rdPtr];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr] <= {macLast, macCtrl, macData};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= nextPtr(wrPtr);
      end
      if (pop) begin
        rdPtr <= nextPtr(rdPtr);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // ------------------------------------------------------------
  // Fault decode
  // ------------------------------------------------------------
  logic lfNow;
  logic rfNow;
  logic blocked;

  assign lfNow   = (linkFault == FAULT_LOCAL);
  assign rfNow   = (linkFault == FAULT_REMOTE);
  // Permit lets frames through whatever the fault state says
  assign blocked = (lfNow || rfNow) && !mgmtOnewayTxPermit;

  // ------------------------------------------------------------
  // Column selection
  // ------------------------------------------------------------
  txstate_t    state;
  txstate_t    next_state;
  logic [31:0] next_txd;
  logic [3:0]  next_txc;
  logic [31:0] fillD;
  logic [3:0]  fillC;
  logic        fwd;

  // Gap fill: Remote Fault under Local Fault, otherwise Idle
  assign fillC = lfNow ? RFAULT_C : IDLE_C;
  assign fillD = lfNow ? RFAULT_D : IDLE_D;

  always_comb begin
    next_state = state;
    next_txc   = fillC;
    next_txd   = fillD;
    bufPop     = 1'b0;
    fwd        = 1'b0;
    unique case (state)
      ST_IDLE, ST_FRAME: begin
        if (bufValid) begin
          bufPop = 1'b1;
          if (blocked) begin
            // Truncate: remainder of the frame is discarded
            next_state = bufLast ? ST_IDLE : ST_DROP;
          end else begin
            fwd      = 1'b1;
            next_txc = bufCtrl;
            next_txd = bufData;
            if (bufLast) begin
              // A fault may land just after the terminate column, so every
              // frame end gets its idle column unless the fault blocks it, which
              // sends the fill column instead; costs one column per frame
              next_state = ST_GAP;
            end else begin
              next_state = ST_FRAME;
            end
          end
        end else if (state == ST_FRAME) begin
          if (blocked) begin
            next_state = ST_DROP;
          end else begin
            // MAC underran inside a frame: poison it
            next_txc = ERROR_C;
            next_txd = ERROR_D;
          end
        end
      end
      ST_GAP: begin
        if (!blocked) begin
          next_txc = IDLE_C;
          next_txd = IDLE_D;
        end
        next_state = ST_IDLE;
      end
      ST_DROP: begin
        bufPop = 1'b1;
        if (bufValid && bufLast) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // One whole column per clock, so every switch lands on lane 0
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      txc <= IDLE_C;
      txd <= IDLE_D;
    end else begin
      txc <= next_txc;
      txd <= next_txd;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  lfCut_a: assert property (@(posedge mclk) disable iff (!rstn)
    (lfNow && !mgmtOnewayTxPermit) |=> (txc == RFAULT_C && txd == RFAULT_D))
    else $error("Local fault without permit did not give Remote Fault column");

  rfIdle_a: assert property (@(posedge mclk) disable iff (!rstn)
    (rfNow && !mgmtOnewayTxPermit) |=> (txc == IDLE_C && txd == IDLE_D))
    else $error("Remote fault without permit did not give Idle column");

  fwdWord_a: assert property (@(posedge mclk) disable iff (!rstn)
    fwd |=> (txd == $past(bufData) && txc == $past(bufCtrl)))
    else $error("Forwarded column differs from buffered MAC column");

  gapIdle_a: assert property (@(posedge mclk) disable iff (!rstn)
    (fwd && bufLast && lfNow) ##1 !blocked |=> (txc == IDLE_C && txd == IDLE_D))
    else $error("No Idle column after frame end under one-way local fault");

  lfFill_a: assert property (@(posedge mclk) disable iff (!rstn)
    (state == ST_IDLE && !bufValid && lfNow && mgmtOnewayTxPermit)
      |=> (txc == RFAULT_C && txd == RFAULT_D))
    else $error("Idle gap under one-way local fault is not Remote Fault");

  okFill_a: assert property (@(posedge mclk) disable iff (!rstn)
    (state == ST_IDLE && !bufValid && linkFault == FAULT_OK)
      |=> (txc == IDLE_C && txd == IDLE_D))
    else $error("Idle gap without fault is not an Idle column");

  rfFill_a: assert property (@(posedge mclk) disable iff (!rstn)
    (state == ST_IDLE && !bufValid && rfNow && mgmtOnewayTxPermit)
      |=> (txc == IDLE_C && txd == IDLE_D))
    else $error("Idle gap under one-way remote fault is not Idle");

  resume_a: assert property (@(posedge mclk) disable iff (!rstn)
    (linkFault == FAULT_OK && bufValid && (state == ST_IDLE || state == ST_FRAME))
      |-> fwd)
    else $error("Buffered MAC column not forwarded with no fault");

  bufBound_a: assert property (@(posedge mclk) disable iff (!rstn)
    (count == (AW+1)'(DEPTH)) |-> (!macReady ##1 (count <= (AW+1)'(DEPTH))))
    else $error("Buffer accepted a word while full");

  rfNoRf_a: assert property (@(posedge mclk) disable iff (!rstn)
    (rfNow && !fwd) |=> !(txc == RFAULT_C && txd == RFAULT_D))
    else $error("Remote Fault column sent while remote fault is reported");

  // ------------------------------------------------------------
  // Frame boundary checks
  // ------------------------------------------------------------
  lastIdle_a: assert property (@(posedge mclk) disable iff (!rstn)
    (fwd && bufLast) ##1 !blocked |=> (txc == IDLE_C && txd == IDLE_D))
    else $error("Frame end not followed by a full Idle column");

  noFwdBlocked_a: assert property (@(posedge mclk) disable iff (!rstn)
    blocked |-> !fwd)
    else $error("MAC column forwarded while fault blocks the path");

  dropFill_a: assert property (@(posedge mclk) disable iff (!rstn)
    (state == ST_DROP) |=> (txc == $past(fillC) && txd == $past(fillD)))
    else $error("Cut frame leaked a column instead of fill");

  gapNoPop_a: assert property (@(posedge mclk) disable iff (!rstn)
    (state == ST_GAP) |-> !pop)
    else $error("Buffer popped during the inserted Idle column");

  errCol_a: assert property (@(posedge mclk) disable iff (!rstn)
    (state == ST_FRAME && !bufValid && !blocked)
      |=> (txc == ERROR_C && txd == ERROR_D))
    else $error("MAC underrun inside a frame did not give an error column");

  // ------------------------------------------------------------
  // Buffer checks and cover points
  // ------------------------------------------------------------
  bufLevel_a: assert property (@(posedge mclk) disable iff (!rstn)
    count <= (AW+1)'(DEPTH))
    else $error("Buffer count above its depth");

  ptrAgree_a: assert property (@(posedge mclk) disable iff (!rstn)
    (count == '0) |-> (wrPtr == rdPtr))
    else $error("Empty buffer with unequal pointers");

  fullStop_a: assert property (@(posedge mclk) disable iff (!rstn)
    !macReady |-> !push)
    else $error("Word pushed while ready is low");

  cutCov: cover property (@(posedge mclk) disable iff (!rstn)
    (state == ST_FRAME) ##1 (lfNow && !mgmtOnewayTxPermit));
  gapCov: cover property (@(posedge mclk) disable iff (!rstn)
    (state == ST_GAP) ##1 (state == ST_IDLE && txc == IDLE_C));
  fullCov: cover property (@(posedge mclk) disable iff (!rstn)
    macValid && !macReady);
  rfFwdCov: cover property (@(posedge mclk) disable iff (!rstn)
    fwd && rfNow && mgmtOnewayTxPermit);
  dropCov: cover property (@(posedge mclk) disable iff (!rstn)
    (state == ST_DROP) ##1 (state == ST_IDLE));

endmodule : rs_oneway_tx
`default_nettype wire

// *** verification/phy_fault_source.sv ***
// Far-end PHY model that reports the received link fault state
`timescale 1ns/100ps
`default_nettype none
module phy_fault_source
  import rs_oneway_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       faultSeen,
  input  wire logic       remoteSeen,
  output logic [1:0]      linkFault
);
  // ----------------------------------------
  // Fault report
  // ----------------------------------------
  // Local detection wins: the link is unusable either way
  always_ff @(posedge mclk) begin
    if (faultSeen) begin
      linkFault <= FAULT_LOCAL;
    end else if (remoteSeen) begin
      linkFault <= FAULT_REMOTE;
    end else begin
      linkFault <= FAULT_OK;
    end
  end
endmodule : phy_fault_source
`default_nettype wire

// *** verification/rs_fault_signal_oneway_tx_test.sv ***
// Self-checking bench for the one-way fault-aware transmit path
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module rs_fault_signal_oneway_tx_test;
  import rs_oneway_pkg::*;
  logic        mclk, resetn, macLast, macValid, macReady, permit, lf, rf;
  logic [31:0] macData, txd;
  logic [3:0]  macCtrl, txc;
  logic [1:0]  linkFault;
  int          failures = 0;
  int          checked = 0;
  int          cycles = 0;
  logic [35:0] seen[$];
  localparam logic [35:0] IDLE = {IDLE_C, IDLE_D};
  localparam logic [35:0] RF   = {RFAULT_C, RFAULT_D};

  rs_oneway_tx uut (.mclk(mclk), .resetn(resetn), .macData(macData), .macCtrl(macCtrl),
    .macLast(macLast), .macValid(macValid), .macReady(macReady), .linkFault(linkFault),
    .mgmtOnewayTxPermit(permit), .txd(txd), .txc(txc));
  phy_fault_source phy (.mclk(mclk), .faultSeen(lf), .remoteSeen(rf), .linkFault(linkFault));

  // ----------------------------------------
  // Clock, column log and hang guard
  // ----------------------------------------
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    seen.push_back({txc, txd});
    cycles++;
    if (cycles == 2000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  // Keeps valid up between columns so no strobe is lowered and raised at one edge
  task automatic send(input int n, input logic [31:0] base, input logic each);
    for (int i = 0; i < n; i++) begin
      macValid = 1;
      macData = base + 32'(i);
      macLast = each || (i == n - 1);
      while (macReady !== 1'b1) tick(1);
      tick(1);
    end
    macValid = 0;
    macLast = 0;
  endtask : send

  function automatic int find(input logic [31:0] d);
    foreach (seen[i]) if (seen[i] === {4'h0, d}) return i;
    return -1;
  endfunction : find

  // An index off the log yields unknown, so a missing column cannot pass
  task automatic at(input string n, input int i, input logic [35:0] e);
    logic [35:0] g;
    g = (i >= 0 && i < seen.size()) ? seen[i] : 'x;
    `CHK(n, e, g)
  endtask : at

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic normal_frame();
    int k;
    seen.delete();
    send(3, 32'hA0A00000, 0);
    tick(5);
    k = find(32'hA0A00000);
    at("normIdleBefore", k - 1, IDLE);
    at("normData1", k + 1, {4'h0, 32'hA0A00001});
    at("normData2", k + 2, {4'h0, 32'hA0A00002});
    at("normIdleAfter", k + 3, IDLE);
  endtask : normal_frame

  task automatic oneway_local();
    int k;
    lf = 1;
    permit = 1;
    tick(4);
    seen.delete();
    send(2, 32'hB0B00000, 0);
    tick(5);
    k = find(32'hB0B00000);
    at("owRfBefore", k - 1, RF);
    at("owData2", k + 1, {4'h0, 32'hB0B00001});
    at("owIdle", k + 2, IDLE);
    at("owRfAfter", k + 3, RF);
    seen.delete();
    send(3, 32'hC0C00000, 1);
    tick(6);
    k = find(32'hC0C00000);
    at("b2bIdle1", k + 1, IDLE);
    at("b2bData2", k + 2, {4'h0, 32'hC0C00001});
    at("b2bIdle2", k + 3, IDLE);
    at("b2bData3", k + 4, {4'h0, 32'hC0C00002});
    at("b2bIdle3", k + 5, IDLE);
    at("b2bRf", k + 6, RF);
  endtask : oneway_local

  task automatic local_cut();
    int k;
    lf = 0;
    permit = 0;
    tick(4);
    seen.delete();
    fork
      send(6, 32'hD0D00000, 0);
      begin
        tick(2);
        lf = 1;
      end
    join
    tick(3);
    `CHK("cutTail", -1, find(32'hD0D00005))
    `CHK("cutMid", -1, find(32'hD0D00004))
    `CHK("cutEarly", -1, find(32'hD0D00002))
    at("cutRf1", seen.size() - 2, RF);
    at("cutRf2", seen.size() - 1, RF);
    lf = 0;
    tick(4);
    seen.delete();
    send(1, 32'hE0E00000, 0);
    tick(5);
    k = find(32'hE0E00000);
    at("recovData", k, {4'h0, 32'hE0E00000});
    at("recovIdle", k + 1, IDLE);
  endtask : local_cut

  task automatic remote_modes();
    int k;
    rf = 1;
    tick(4);
    seen.delete();
    send(2, 32'hF0F00000, 0);
    tick(5);
    `CHK("rfBlocked", -1, find(32'hF0F00000))
    at("rfIdleFill", seen.size() - 1, IDLE);
    permit = 1;
    tick(3);
    seen.delete();
    send(2, 32'h10100000, 0);
    tick(5);
    k = find(32'h10100000);
    at("rfOwData", k + 1, {4'h0, 32'h10100001});
    at("rfOwIdle", k + 2, IDLE);
    rf = 0;
  endtask : remote_modes

  task automatic reset_again();
    int k;
    resetn = 0;
    tick(2);
    `CHK("midRstTxc", IDLE_C, txc)
    `CHK("midRstReady", 1'b1, macReady)
    resetn = 1;
    tick(4);
    seen.delete();
    send(1, 32'h20200000, 0);
    tick(5);
    k = find(32'h20200000);
    at("rstData", k, {4'h0, 32'h20200000});
    at("rstIdle", k + 1, IDLE);
  endtask : reset_again

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    resetn = 0;
    macData = '0;
    macCtrl = '0;
    macLast = 0;
    macValid = 0;
    permit = 0;
    lf = 0;
    rf = 0;
    tick(16);
    `CHK("resetTxc", IDLE_C, txc)
    `CHK("resetTxd", IDLE_D, txd)
    `CHK("resetReady", 1'b1, macReady)
    resetn = 1;
    tick(4);
    normal_frame();
    oneway_local();
    local_cut();
    remote_modes();
    reset_again();
    tally_and_finish();
  end
endmodule : rs_fault_signal_oneway_tx_test
`default_nettype wire
